// ### logic/acs_conv_ctrl.sv
// Notes on behaviour
// - A conversion starts from a falling request on conversion_start_n, or by automatic reconversion in low-power mode while it is held low.
// - A running conversion finishes; new starts and power-down are ignored meanwhile.
// - Start works regardless of chip select and read.
// - Automatic mode: start held low while idle times acquisition, then reconverts.
// - Automatic reconversion only in the low-power mode, never fast or normal.
// - Self-repeating rate may slightly exceed the low-power mode's rated throughput.
// - Low-power mode enters reduced power after each conversion, through acquisition.
// - Interface keeps working during acquisition, low-power included.
// - Outputs float unless chip select and read are both low.
// - Serial output shares the parallel data pins.
// - Coding select chooses straight binary or twos complement.
// - Over full scale gives FFFF binary or 7FFF twos complement.
// - Under negative full scale gives 0000 binary or 8000 twos complement.
// - Normal mode takes starts at any spacing up to its rated rate.
`timescale 1ns/1ps
`default_nettype none

module acs_conv_ctrl (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Conversion control pins
	input wire logic conversion_start_n,
	input wire logic power_down_in,
	input wire acs_pkg::acs_mode_t modeSel,
	input wire logic output_coding_select,
	// Analog front end sample
	input wire acs_pkg::acs_sample_t sampleIn,
	// Interface pins
	input wire logic chipSelect_n,
	input wire logic read_n,
	input wire logic serialSel,
	input wire logic serialShift,
	output acs_pkg::acs_bus_t busPins,
	// Status
	output logic busy,
	output logic lowPower,
	output logic sampleTake
);
	import acs_pkg::*;

	////////////////////////////////////////////////////////////////
	// Pin synchronisers: three stages, change taken when last two agree
	logic [2:0] startSync_reg, startSync_next;
	logic [2:0] pdSync_reg, pdSync_next;
	logic [2:0] csSync_reg, csSync_next;
	logic [2:0] rdSync_reg, rdSync_next;
	logic [2:0] shSync_reg, shSync_next;
	logic startLvl_reg, startLvl_next;
	logic pdLvl_reg, pdLvl_next;
	logic csLvl_reg, csLvl_next;
	logic rdLvl_reg, rdLvl_next;
	logic shLvl_reg, shLvl_next;

	always_comb begin
		startSync_next = {startSync_reg[1:0], conversion_start_n};
		pdSync_next = {pdSync_reg[1:0], power_down_in};
		csSync_next = {csSync_reg[1:0], chipSelect_n};
		rdSync_next = {rdSync_reg[1:0], read_n};
		shSync_next = {shSync_reg[1:0], serialShift};
		startLvl_next = (startSync_reg[2] == startSync_reg[1]) ? startSync_reg[2] : startLvl_reg;
		pdLvl_next = (pdSync_reg[2] == pdSync_reg[1]) ? pdSync_reg[2] : pdLvl_reg;
		csLvl_next = (csSync_reg[2] == csSync_reg[1]) ? csSync_reg[2] : csLvl_reg;
		rdLvl_next = (rdSync_reg[2] == rdSync_reg[1]) ? rdSync_reg[2] : rdLvl_reg;
		shLvl_next = (shSync_reg[2] == shSync_reg[1]) ? shSync_reg[2] : shLvl_reg;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			startSync_reg <= 3'h7;
			pdSync_reg <= 3'h0;
			csSync_reg <= 3'h7;
			rdSync_reg <= 3'h7;
			shSync_reg <= 3'h0;
			startLvl_reg <= 1'h1;
			pdLvl_reg <= 1'h0;
			csLvl_reg <= 1'h1;
			rdLvl_reg <= 1'h1;
			shLvl_reg <= 1'h0;
		end else begin
			startSync_reg <= startSync_next;
			pdSync_reg <= pdSync_next;
			csSync_reg <= csSync_next;
			rdSync_reg <= rdSync_next;
			shSync_reg <= shSync_next;
			startLvl_reg <= startLvl_next;
			pdLvl_reg <= pdLvl_next;
			csLvl_reg <= csLvl_next;
			rdLvl_reg <= rdLvl_next;
			shLvl_reg <= shLvl_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Conversion sequencer
	acs_state_t state_reg, state_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic startPrev_reg, startPrev_next;
	logic [15:0] result_reg, result_next;
	logic lowPower_reg, lowPower_next;
	logic powerDown_reg, powerDown_next;
	logic startFall;
	logic [CNT_W-1:0] convLen;
	logic [15:0] coded;

	// Falling edge of the filtered start level; cs and rd play no part
	assign startFall = startPrev_reg & ~startLvl_reg;

	always_comb begin
		case (modeSel)
			MODE_FAST: convLen = CNT_W'(CONV_CYC_FAST - 1);
			MODE_IMPULSE: convLen = CNT_W'(CONV_CYC_IMPULSE - 1);
			default: convLen = CNT_W'(CONV_CYC_NORMAL - 1);
		endcase
	end

	// Range clamp then coding; twos complement is the binary code with MSB flipped
	always_comb begin
		if (sampleIn.overRange) begin
			coded = output_coding_select ? CODE_SB_MAX : CODE_TC_MAX;
		end else if (sampleIn.underRange) begin
			coded = output_coding_select ? CODE_SB_MIN : CODE_TC_MIN;
		end else begin
			coded = output_coding_select ? sampleIn.code : (sampleIn.code ^ CODE_MSB);
		end
	end

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		startPrev_next = startLvl_reg;
		result_next = result_reg;
		lowPower_next = lowPower_reg;
		powerDown_next = powerDown_reg;
		sampleTake = 1'b0;
		case (state_reg)
			ST_ACQ: begin
				// Power-down only honoured while idle
				powerDown_next = pdLvl_reg;
				if (startFall && !pdLvl_reg) begin
					// Any spacing is accepted; the conversion length sets the rate
					state_next = ST_CONV;
					cnt_next = convLen;
					sampleTake = 1'b1;
					lowPower_next = 1'b0;
				end else if (modeSel == MODE_IMPULSE && !startLvl_reg && !pdLvl_reg
					&& !startPrev_reg) begin
					// Start held low while idle: time acquisition internally
					state_next = ST_AUTOACQ;
					cnt_next = CNT_W'(ACQ_CYC_AUTO - 1);
				end
			end
			ST_CONV: begin
				// Start and power-down ignored until done
				if (cnt_reg == '0) begin
					state_next = ST_ACQ;
					result_next = coded;
					lowPower_next = (modeSel == MODE_IMPULSE);
				end else begin
					cnt_next = cnt_reg - 1'b1;
				end
			end
			ST_AUTOACQ: begin
				// Releasing start or leaving the mode stops the self-repeat
				if (startLvl_reg || modeSel != MODE_IMPULSE || pdLvl_reg) begin
					state_next = ST_ACQ;
				end else if (cnt_reg == '0) begin
					// Short internal acquisition may run above rated throughput
					state_next = ST_CONV;
					cnt_next = convLen;
					sampleTake = 1'b1;
					lowPower_next = 1'b0;
				end else begin
					cnt_next = cnt_reg - 1'b1;
				end
			end
			default: state_next = ST_ACQ;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_reg <= ST_ACQ;
			cnt_reg <= '0;
			startPrev_reg <= 1'b1;
			result_reg <= RESULT_RST;
			lowPower_reg <= 1'b0;
			powerDown_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			startPrev_reg <= startPrev_next;
			result_reg <= result_next;
			lowPower_reg <= lowPower_next;
			powerDown_reg <= powerDown_next;
		end
	end

	assign busy = (state_reg == ST_CONV);
	assign lowPower = lowPower_reg | powerDown_reg;

	////////////////////////////////////////////////////////////////
	// Output interface, live in every phase so reads between conversions work
	logic [15:0] shift_reg, shift_next;
	logic shPrev_reg, shPrev_next;
	logic enable;
	acs_bus_t bus_reg, bus_next;

	assign enable = ~csLvl_reg & ~rdLvl_reg;

	always_comb begin
		shPrev_next = shLvl_reg;
		shift_next = shift_reg;
		if (!enable) begin
			shift_next = result_reg;
		end else if (shLvl_reg && !shPrev_reg) begin
			shift_next = {shift_reg[14:0], 1'b0};
		end
		bus_next.dataOut = result_reg;
		bus_next.dataOe = enable ? 16'h0000 : 16'hFFFF;
		if (serialSel) begin
			// Serial data leaves MSB first on bit 15 of the shared bus
			bus_next.dataOut = {shift_reg[15], 15'h0000};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			shift_reg <= RESULT_RST;
			shPrev_reg <= 1'b0;
			bus_reg <= {RESULT_RST, 16'hFFFF};
		end else begin
			shift_reg <= shift_next;
			shPrev_reg <= shPrev_next;
			bus_reg <= bus_next;
		end
	end

	assign busPins = bus_reg;

endmodule // acs_conv_ctrl
`default_nettype wire

// ### logic/acs_pkg.sv
package acs_pkg;

	// Result and timing figures
	localparam int DATA_W = 16;
	localparam int CLK_MHZ = 100;
	// Conversion phase length per mode, in ns
	localparam int CONV_NS_FAST = 750;
	localparam int CONV_NS_NORMAL = 1000;
	localparam int CONV_NS_IMPULSE = 1250;
	// Internally timed acquisition in automatic mode, in ns
	localparam int ACQ_NS_AUTO = 250;
	localparam int CONV_CYC_FAST = (CONV_NS_FAST * CLK_MHZ) / 1000;
	localparam int CONV_CYC_NORMAL = (CONV_NS_NORMAL * CLK_MHZ) / 1000;
	localparam int CONV_CYC_IMPULSE = (CONV_NS_IMPULSE * CLK_MHZ) / 1000;
	localparam int ACQ_CYC_AUTO = (ACQ_NS_AUTO * CLK_MHZ) / 1000;
	localparam int CNT_W = 8;

	// Full-scale codes, MSB mask and reset result
	localparam logic [15:0] CODE_SB_MAX = 16'hFFFF;
	localparam logic [15:0] CODE_SB_MIN = 16'h0000;
	localparam logic [15:0] CODE_TC_MAX = 16'h7FFF;
	localparam logic [15:0] CODE_TC_MIN = 16'h8000;
	localparam logic [15:0] CODE_MSB = 16'h8000;
	localparam logic [15:0] RESULT_RST = 16'h0000;

	typedef enum logic [1:0] {
		MODE_FAST = 2'b00,
		MODE_NORMAL = 2'b01,
		MODE_IMPULSE = 2'b10
	} acs_mode_t;

	typedef enum logic [1:0] {
		ST_ACQ = 2'b00,
		ST_CONV = 2'b01,
		ST_AUTOACQ = 2'b10
	} acs_state_t;

	// Sample from the analog front end, with range flags
	typedef struct packed {
		logic [15:0] code;
		logic overRange;
		logic underRange;
	} acs_sample_t;

	// Data bus pins: output, and output enable (low drives)
	typedef struct packed {
		logic [15:0] dataOut;
		logic [15:0] dataOe;
	} acs_bus_t;

endpackage

// ### tb/acs_conv_props.sv
`timescale 1ns/1ps
`default_nettype none
module acs_conv_props import acs_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Control pins
	input wire logic conversion_start_n,
	input wire acs_pkg::acs_mode_t modeSel,
	input wire logic chipSelect_n,
	input wire logic read_n,
	// Outputs
	input wire acs_pkg::acs_bus_t busPins,
	input wire logic busy,
	input wire logic lowPower,
	input wire logic sampleTake
);
	logic [7:0] busyCnt_reg, busyCnt_next, lowCnt_reg, lowCnt_next;
	// Low count saturates so a long hold never wraps back into the window
	always_comb begin
		busyCnt_next = busy ? busyCnt_reg + 8'h01 : 8'h00;
		lowCnt_next = conversion_start_n ? 8'h00 : lowCnt_reg + {7'h00, lowCnt_reg != 8'hC8};
	end
	always_ff @(posedge sys_clk) begin
		busyCnt_reg <= sys_rst ? 8'h00 : busyCnt_next;
		lowCnt_reg <= sys_rst ? 8'h00 : lowCnt_next;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	sequence autoGap;
		!busy[*8] ##[12:22] $rose(busy);
	endsequence
	// Take pulse leads busy by one cycle, as busy comes from the state register
	sequence convLaunch;
		!busy ##1 busy;
	endsequence
	float_when_off_a: assert property ((chipSelect_n || read_n)[*6] |-> busPins.dataOe == 16'hFFFF)
		else $error("bus driven while deselected");
	drive_when_on_a: assert property ((!chipSelect_n && !read_n)[*7] |-> busPins.dataOe == 16'h0000)
		else $error("bus not driven while enabled");
	conv_length_a: assert property ($fell(busy) |-> busyCnt_reg == CONV_CYC_FAST
		|| busyCnt_reg == CONV_CYC_NORMAL || busyCnt_reg == CONV_CYC_IMPULSE)
		else $error("conversion length wrong");
	take_with_busy_a: assert property ($rose(busy) |-> $past(sampleTake))
		else $error("busy rose without sample");
	take_idle_only_a: assert property (sampleTake |-> convLaunch)
		else $error("sample taken while busy");
	no_repeat_a: assert property (modeSel != MODE_IMPULSE && lowCnt_reg > 8'h8C |-> !busy)
		else $error("self restart outside low power mode");
	auto_repeat_a: assert property ($fell(busy) && modeSel == MODE_IMPULSE && lowCnt_reg > 8'h64
		|-> autoGap)
		else $error("no automatic restart");
	low_power_a: assert property ($fell(busy) && modeSel == MODE_IMPULSE |-> ##[0:1] lowPower)
		else $error("low power not entered");
endmodule // acs_conv_props
bind acs_conv_ctrl acs_conv_props i_props (.sys_clk, .sys_rst, .conversion_start_n, .modeSel,
	.chipSelect_n, .read_n, .busPins, .busy, .lowPower, .sampleTake);
`default_nettype wire

// ### tb/acs_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module acs_front_model import acs_pkg::*; (
	// Clock
	input wire logic sys_clk,
	// Converter side
	input wire logic busy,
	input wire acs_pkg::acs_sample_t nextSample,
	output acs_pkg::acs_sample_t sampleIn
);
	acs_sample_t sampleHold_reg, sampleHold_next;
	// Input only moves outside a conversion, so it is settled when busy falls
	always_comb sampleHold_next = busy ? sampleHold_reg : nextSample;
	always_ff @(posedge sys_clk) sampleHold_reg <= sampleHold_next;
	assign sampleIn = sampleHold_reg;
endmodule // acs_front_model
`default_nettype wire

// ### tb/adc_conversion_start_and_output_enable_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_start_and_output_enable_tb;
	import acs_pkg::*;
	logic sys_clk, sys_rst, conversion_start_n, power_down_in, output_coding_select;
	logic chipSelect_n, read_n, serialSel, serialShift, busy, lowPower, sampleTake;
	acs_mode_t modeSel;
	acs_sample_t nextSample, sampleIn;
	acs_bus_t busPins;
	int n_fail = 0, check_count = 0, nConv = 0, n0, k, i, r, seed = 32'h817e;
	logic [15:0] expQ[$];
	acs_front_model i_front (.sys_clk, .busy, .nextSample, .sampleIn);
	acs_conv_ctrl i_dut (.sys_clk, .sys_rst, .conversion_start_n, .power_down_in, .modeSel,
		.output_coding_select, .sampleIn, .chipSelect_n, .read_n, .serialSel, .serialShift,
		.busPins, .busy, .lowPower, .sampleTake);
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	function automatic logic [15:0] modelCode(acs_sample_t s);
		if (s.overRange) return output_coding_select ? 16'hFFFF : 16'h7FFF;
		if (s.underRange) return output_coding_select ? 16'h0000 : 16'h8000;
		return output_coding_select ? s.code : s.code ^ 16'h8000;
	endfunction
	always @(negedge busy) if (!sys_rst) begin
		nConv++;
		expQ.push_back(modelCode(sampleIn));
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic check16(input string what, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic waitBusy(input logic lvl);
		int j;
		j = 0;
		while (busy !== lvl && j < 400) begin
			tick(1);
			j++;
		end
		if (j == 400) begin
			n_fail++;
			summarize();
		end
	endtask
	task automatic convert(input logic sel);
		chipSelect_n <= sel;
		read_n <= sel;
		conversion_start_n <= 1'b0;
		tick(8);
		check16("busy", 16'h0001, {15'h0, busy});
		conversion_start_n <= 1'b1;
		waitBusy(1'b0);
	endtask
	task automatic readPar;
		chipSelect_n <= 1'b0;
		read_n <= 1'b0;
		tick(8);
		check16("data", expQ[$], busPins.dataOut);
		check16("enable", 16'h0000, busPins.dataOe);
		chipSelect_n <= 1'b1;
		read_n <= 1'b1;
		tick(8);
		check16("float", 16'hFFFF, busPins.dataOe);
	endtask
	initial begin
		{conversion_start_n, chipSelect_n, read_n} = 3'h7;
		{power_down_in, output_coding_select, serialSel, serialShift} = 4'h0;
		modeSel = MODE_NORMAL;
		nextSample = '0;
		sys_rst = 1'b1;
		tick(16);
		sys_rst <= 1'b0;
		tick(2);
		for (k = 0; k < 8; k++) begin
			r = $random(seed);
			output_coding_select <= k[0];
			nextSample <= {r[15:0], k[2:1] == 2'b01, k[2:1] == 2'b10};
			tick(2);
			convert(k[1]);
			readPar();
		end
		$display("test coding done");
		for (k = 0; k < 2; k++) begin
			modeSel <= k[0] ? MODE_NORMAL : MODE_FAST;
			n0 = nConv;
			conversion_start_n <= 1'b0;
			tick(10);
			power_down_in <= 1'b1;
			tick(290);
			power_down_in <= 1'b0;
			conversion_start_n <= 1'b1;
			tick(10);
			check16("single conversion", 16'h0001, 16'(nConv - n0));
		end
		$display("test no repeat done");
		modeSel <= MODE_IMPULSE;
		n0 = nConv;
		conversion_start_n <= 1'b0;
		tick(600);
		// Release only while busy, so a running acquisition is never cut short
		waitBusy(1'b1);
		conversion_start_n <= 1'b1;
		tick(4);
		waitBusy(1'b0);
		tick(2);
		check16("auto repeat", 16'h0001, 16'(nConv - n0 > 3));
		check16("low power", 16'h0001, {15'h0, lowPower});
		readPar();
		serialSel <= 1'b1;
		chipSelect_n <= 1'b0;
		read_n <= 1'b0;
		tick(8);
		for (i = 15; i >= 0; i--) begin
			check16("serial bit", {15'h0, expQ[$][i]}, {15'h0, busPins.dataOut[15]});
			serialShift <= 1'b1;
			tick(6);
			serialShift <= 1'b0;
			tick(6);
		end
		$display("test low power done");
		summarize();
	end
endmodule // adc_conversion_start_and_output_enable_tb
`default_nettype wire
